// ### shared/ioc_defines.svh
// constants for the channel command control block
`ifndef IOC_DEFINES_SVH
`define IOC_DEFINES_SVH

// channel context
`define IOC_NCH 4
`define IOC_CMD_STEP 16'h0002
`define IOC_CNT_STEP 16'h0001
`define IOC_BA_STEP 19'h00001
`define IOC_CNT_ZERO 16'h0000

// channel flag bit numbers
`define IOC_FL_DC 0
`define IOC_FL_IZC 1
`define IOC_FL_CC 2
`define IOC_FL_ICE 3
`define IOC_FL_HTE 4
`define IOC_FL_IUE 5
`define IOC_FL_SIL 6
`define IOC_FL_SKIP 7

// terminal order and order in data lines
`define IOC_TO_INT 0
`define IOC_TO_CHAIN 2
`define IOC_TO_HALT 3
`define IOC_OI_TERR 0
`define IOC_OI_ILEN 1
`define IOC_OI_CHEND 3
`define IOC_OI_UNUSUAL 4

// command word fields
`define IOC_EV_ORDER 31:24
`define IOC_EV_BADDR 18:0
`define IOC_EV_TARGET 15:0
`define IOC_OD_FLAG_TOP 31
`define IOC_OD_COUNT 15:0

// instruction word written by software
`define IOC_IN_EA 10:0
`define IOC_IN_DEV 7:0
`define IOC_IN_CHAN 1:0
`define IOC_IN_IOP 10:8
`define IOC_IN_OP 12:11
`define IOC_IN_RET 14:13
`define IOC_IN_W 15
`define IOC_RET_NONE 2'h0
`define IOC_RET_20 2'h1
`define IOC_RET_2021 2'h2

// return cells and status layout
`define IOC_CELL20 16'h0020
`define IOC_CELL21 16'h0021
`define IOC_ST_W 15
`define IOC_ST_DEV 14:7

// register offsets
`define IOC_REG_INSTR 4'h0
`define IOC_REG_CMDADDR 4'h1
`define IOC_REG_SEL 4'h2
`define IOC_REG_CHSTAT 4'h3
`define IOC_REG_COUNT 4'h4
`define IOC_REG_BADDR 4'h5
`define IOC_REG_LASTST 4'h6

`endif

// ### shared/ioc_pkg.sv
// types shared by the channel command control block
package ioc_pkg;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_EVEN = 6'h02,
        ST_ODD = 6'h04,
        ST_INWAIT = 6'h08,
        ST_RET20 = 6'h10,
        ST_RET21 = 6'h20
    } ioc_state_t;

    typedef enum logic [2:0] {
        ORD_CONTROL = 3'h0,
        ORD_WRITE = 3'h1,
        ORD_READ = 3'h2,
        ORD_READBACK = 3'h3,
        ORD_SENSE = 3'h4,
        ORD_BRANCH = 3'h5,
        ORD_STOP = 3'h6,
        ORD_ILLEGAL = 3'h7
    } ioc_order_t;

    typedef enum logic [1:0] {
        IN_START = 2'h0,
        IN_HALT = 2'h1,
        IN_TEST = 2'h2,
        IN_TESTDEV = 2'h3
    } ioc_instr_t;

endpackage

// ### src/ioc_command_control.sv
// per-channel command fetch, flag handling and instruction return cells
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`include "ioc_defines.svh"
module ioc_command_control import ioc_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // register port
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    // controller service requests
    input wire logic orderOutReq,
    input wire logic orderInReq,
    input wire logic dataByteReq,
    input wire logic [1:0] reqChan,
    input wire logic [7:0] orderInByte,
    output logic busy,
    // answers to controllers
    output logic orderValid,
    output logic [7:0] orderByte,
    output logic termValid,
    output logic [7:0] termByte,
    output logic [1:0] ansChan,
    output logic [18:0] dataAddr,
    output logic dataMemEn,
    // instructions to controllers
    output logic instrValid,
    output logic [1:0] instrCode,
    output logic [2:0] instrIop,
    output logic [7:0] instrDev,
    input wire logic instrDone,
    input wire logic [14:0] instrStatus,
    input wire logic [7:0] instrDevStatus,
    // main memory
    output logic memReq,
    output logic memWe,
    output logic [15:0] memAddr,
    output logic [31:0] memWdata,
    input wire logic memAck,
    input wire logic [31:0] memRdata,
    input wire logic memParErr
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    ioc_state_t state;
    ioc_state_t next_state;
    ioc_order_t kind;

    logic [18:0] byteAddr [`IOC_NCH];
    logic [15:0] cmdAddr [`IOC_NCH];
    logic [15:0] byteCnt [`IOC_NCH];
    logic [7:0] flags [`IOC_NCH];
    logic [`IOC_NCH-1:0] backward;
    logic [`IOC_NCH-1:0] fresh;

    logic [1:0] curChan;
    logic fwd;
    logic [15:0] cmdAddrReg;
    logic [1:0] chanSel;
    logic [`IOC_IN_W-1:0] instrWord;
    logic instrPend;
    logic [31:0] lastStatus;

    logic [15:0] nextCnt;
    logic zeroNow;
    logic chainFetch;
    logic fetchStart;
    logic instrTake;
    logic [15:0] fetchAddr;
    logic evenDone;
    logic oddDone;
    logic [1:0] termChan;
    logic termIn;
    logic termZero;
    logic termPar;
    logic [7:0] termCalc;
    logic termNeed;
    logic [14:0] stdStatus;
    logic [31:0] cell20;
    logic [31:0] cell21;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    ioc_order_decode orderDecode (
        .order(memRdata[`IOC_EV_ORDER]),
        .kind(kind)
    );

    ioc_terminal_order terminalOrder (
        .flags(flags[termChan]),
        .orderIn(termIn),
        .inByte(orderInByte),
        .zeroCount(termZero),
        .parityErr(termPar),
        .termByte(termCalc),
        .need(termNeed)
    );

    // flags are stored with flag 0 at bit 0; the odd word has it on top
    function automatic logic [7:0] flag_field(input logic [31:0] word);
        logic [7:0] f;
        f = 8'h00;
        for (int i = 0; i < 8; i++) begin
            f[i] = word[`IOC_OD_FLAG_TOP - i];
        end
        return f;
    endfunction

    always_comb begin
        nextCnt = byteCnt[reqChan] + `IOC_CNT_STEP;
        zeroNow = dataByteReq && (nextCnt == `IOC_CNT_ZERO);
        chainFetch = zeroNow && flags[reqChan][`IOC_FL_DC];
        fetchStart = (state == ST_IDLE) && (orderOutReq || chainFetch);
        instrTake = (state == ST_IDLE) && !fetchStart && instrPend;
        // a channel just started fetches exactly the address software gave
        fetchAddr = fresh[reqChan] ? cmdAddr[reqChan]
            : cmdAddr[reqChan] + `IOC_CMD_STEP;
        evenDone = (state == ST_EVEN) && memAck && !memParErr;
        oddDone = (state == ST_ODD) && memAck && !memParErr;
        termChan = (state == ST_IDLE) ? reqChan : curChan;
        termIn = (state == ST_IDLE) && orderInReq;
        termZero = (state == ST_IDLE) && zeroNow;
        termPar = ((state == ST_EVEN) || (state == ST_ODD)) && memAck && memParErr;
        stdStatus = instrStatus;
        if (instrWord[`IOC_IN_OP] == IN_TESTDEV) begin
            stdStatus[`IOC_ST_DEV] = instrDevStatus;
        end
        cell20 = {cmdAddr[curChan], 5'h00, instrWord[`IOC_IN_EA]};
        cell21 = {stdStatus, 1'b0, byteCnt[curChan]};
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (fetchStart) begin
                    next_state = ST_EVEN;
                end else if (instrTake) begin
                    next_state = ST_INWAIT;
                end
            end
            ST_EVEN: begin
                if (memAck) begin
                    if (memParErr || kind == ORD_STOP) begin
                        next_state = ST_IDLE;
                    end else if (kind != ORD_BRANCH) begin
                        next_state = ST_ODD;
                    end
                end
            end
            ST_ODD: begin
                if (memAck) begin
                    next_state = ST_IDLE;
                end
            end
            ST_INWAIT: begin
                if (instrDone) begin
                    if (instrWord[`IOC_IN_RET] == `IOC_RET_20
                        || instrWord[`IOC_IN_RET] == `IOC_RET_2021) begin
                        next_state = ST_RET20;
                    end else begin
                        next_state = ST_IDLE;
                    end
                end
            end
            ST_RET20: begin
                if (memAck) begin
                    next_state = (instrWord[`IOC_IN_RET] == `IOC_RET_2021)
                        ? ST_RET21 : ST_IDLE;
                end
            end
            ST_RET21: begin
                if (memAck) begin
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= ST_IDLE;
            busy <= 1'b0;
            curChan <= 2'h0;
            fwd <= 1'b0;
        end else begin
            state <= next_state;
            // requests are only taken in idle; busy warns controllers off
            busy <= (next_state != ST_IDLE);
            if (fetchStart) begin
                curChan <= reqChan;
                fwd <= orderOutReq;
            end else if (instrTake) begin
                curChan <= instrWord[`IOC_IN_CHAN];
            end
        end
    end

    // ------------------------------------------------------------
    // memory port
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            memReq <= 1'b0;
            memWe <= 1'b0;
            memAddr <= 16'h0000;
            memWdata <= 32'h00000000;
        end else begin
            memReq <= (next_state != ST_IDLE) && (next_state != ST_INWAIT);
            memWe <= (next_state == ST_RET20) || (next_state == ST_RET21);
            if (fetchStart) begin
                memAddr <= fetchAddr;
            end else if (evenDone && kind == ORD_BRANCH) begin
                memAddr <= memRdata[`IOC_EV_TARGET];
            end else if (evenDone) begin
                memAddr <= memAddr + 16'h0001;
            end else if (state == ST_INWAIT && next_state == ST_RET20) begin
                memAddr <= `IOC_CELL20;
                memWdata <= cell20;
            end else if (state == ST_RET20 && next_state == ST_RET21) begin
                memAddr <= `IOC_CELL21;
                memWdata <= cell21;
            end
        end
    end

    // ------------------------------------------------------------
    // channel context
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int c = 0; c < `IOC_NCH; c++) begin
                byteAddr[c] <= 19'h00000;
                cmdAddr[c] <= 16'h0000;
                byteCnt[c] <= 16'h0000;
                flags[c] <= 8'h00;
            end
            backward <= '0;
            fresh <= '0;
        end else begin
            if (fetchStart) begin
                cmdAddr[reqChan] <= fetchAddr;
                fresh[reqChan] <= 1'b0;
            end
            if (state == ST_IDLE && dataByteReq) begin
                byteCnt[reqChan] <= nextCnt;
                byteAddr[reqChan] <= backward[reqChan]
                    ? byteAddr[reqChan] - `IOC_BA_STEP
                    : byteAddr[reqChan] + `IOC_BA_STEP;
            end
            if (evenDone && kind == ORD_BRANCH) begin
                cmdAddr[curChan] <= memRdata[`IOC_EV_TARGET];
            end else if (evenDone && kind != ORD_STOP) begin
                byteAddr[curChan] <= memRdata[`IOC_EV_BADDR];
                backward[curChan] <= (kind == ORD_READBACK);
            end
            if (oddDone) begin
                flags[curChan] <= flag_field(memRdata);
                byteCnt[curChan] <= memRdata[`IOC_OD_COUNT];
            end
            if (instrTake && instrWord[`IOC_IN_OP] == IN_START) begin
                cmdAddr[instrWord[`IOC_IN_CHAN]] <= cmdAddrReg;
                fresh[instrWord[`IOC_IN_CHAN]] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // controller answers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            orderValid <= 1'b0;
            orderByte <= 8'h00;
            termValid <= 1'b0;
            termByte <= 8'h00;
            ansChan <= 2'h0;
            dataAddr <= 19'h00000;
            dataMemEn <= 1'b0;
        end else begin
            // the order byte is sent once and kept nowhere else
            orderValid <= evenDone && fwd && kind != ORD_BRANCH;
            termValid <= termNeed && (state == ST_IDLE || termPar);
            dataMemEn <= 1'b0;
            if (evenDone) begin
                orderByte <= memRdata[`IOC_EV_ORDER];
            end
            if (termNeed) begin
                termByte <= termCalc;
            end
            if (evenDone || termNeed || (state == ST_IDLE && dataByteReq)) begin
                ansChan <= termChan;
            end
            if (state == ST_IDLE && dataByteReq) begin
                dataAddr <= byteAddr[reqChan];
                // skipped commands still count and step, but touch no data
                dataMemEn <= !flags[reqChan][`IOC_FL_SKIP];
            end
        end
    end

    // ------------------------------------------------------------
    // instruction issue
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            instrValid <= 1'b0;
            instrCode <= 2'h0;
            instrIop <= 3'h0;
            instrDev <= 8'h00;
            lastStatus <= 32'h00000000;
        end else begin
            instrValid <= instrTake;
            if (instrTake) begin
                instrCode <= instrWord[`IOC_IN_OP];
                instrIop <= instrWord[`IOC_IN_IOP];
                instrDev <= instrWord[`IOC_IN_DEV];
            end
            if (state == ST_INWAIT && instrDone) begin
                lastStatus <= cell21;
            end
        end
    end

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmdAddrReg <= 16'h0000;
            chanSel <= 2'h0;
            instrWord <= '0;
            instrPend <= 1'b0;
        end else begin
            // a new write wins over the take in the same cycle
            if (regWr && regAddr == `IOC_REG_INSTR) begin
                instrWord <= regWdata[`IOC_IN_W-1:0];
                instrPend <= 1'b1;
            end else if (instrTake) begin
                instrPend <= 1'b0;
            end
            if (regWr && regAddr == `IOC_REG_CMDADDR) begin
                cmdAddrReg <= regWdata[15:0];
            end
            if (regWr && regAddr == `IOC_REG_SEL) begin
                chanSel <= regWdata[1:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            regRdata <= 32'h00000000;
        end else if (regRd) begin
            unique case (regAddr)
                `IOC_REG_INSTR: regRdata <= {busy, instrPend, 14'h0000,
                    1'b0, instrWord};
                `IOC_REG_CMDADDR: regRdata <= {16'h0000, cmdAddr[chanSel]};
                `IOC_REG_SEL: regRdata <= {30'h00000000, chanSel};
                `IOC_REG_CHSTAT: regRdata <= {22'h000000, fresh[chanSel],
                    backward[chanSel], flags[chanSel]};
                `IOC_REG_COUNT: regRdata <= {16'h0000, byteCnt[chanSel]};
                `IOC_REG_BADDR: regRdata <= {13'h0000, byteAddr[chanSel]};
                `IOC_REG_LASTST: regRdata <= lastStatus;
                default: regRdata <= 32'h00000000;
            endcase
        end else begin
            regRdata <= 32'h00000000;
        end
    end

endmodule

// ### src/ioc_order_decode.sv
// decodes the order byte of an even command word
`timescale 1ns/100ps
module ioc_order_decode import ioc_pkg::*; (
    // order byte
    input wire logic [7:0] order,
    // decoded kind
    output ioc_order_t kind
);

    // modifier bits are looked at only to tell a stop from an illegal order (order[6:4]); they travel on to the controller
    always_comb begin
        kind = ORD_ILLEGAL;
        unique case (order[1:0])
            2'h3: kind = ORD_CONTROL;
            2'h1: kind = ORD_WRITE;
            2'h2: kind = ORD_READ;
            default: begin
                if (order[3:2] == 2'h3) begin
                    kind = ORD_READBACK;
                end else if (order[3:2] == 2'h1) begin
                    kind = ORD_SENSE;
                end else if (order[3:2] == 2'h2) begin
                    kind = ORD_BRANCH;
                end else if (order[6:4] == 3'h0) begin
                    kind = ORD_STOP;
                end
            end
        endcase
    end

endmodule

// ### src/ioc_terminal_order.sv
// builds the terminal order byte from channel flags and events
`timescale 1ns/100ps
module ioc_terminal_order (
    // channel flags
    input wire logic [7:0] flags,
    // events
    input wire logic orderIn,
    input wire logic [7:0] inByte,
    input wire logic zeroCount,
    input wire logic parityErr,
    // result
    output logic [7:0] termByte,
    output logic need
);

    logic chEnd;
    logic lenErr;
    logic halt;
    logic intr;
    logic chain;

    always_comb begin
        chEnd = orderIn & inByte[`IOC_OI_CHEND];
        // length errors vanish entirely when suppressed
        lenErr = inByte[`IOC_OI_ILEN] & ~flags[`IOC_FL_SIL];
        halt = flags[`IOC_FL_HTE] & (parityErr
            | (orderIn & (inByte[`IOC_OI_TERR] | lenErr)));
        chain = chEnd & flags[`IOC_FL_CC];
        intr = (zeroCount & flags[`IOC_FL_IZC])
            | (chEnd & flags[`IOC_FL_ICE])
            | (orderIn & inByte[`IOC_OI_UNUSUAL] & flags[`IOC_FL_IUE]);
        termByte = 8'h00;
        termByte[`IOC_TO_INT] = intr;
        termByte[`IOC_TO_CHAIN] = chain;
        termByte[`IOC_TO_HALT] = halt;
        // an order in is always answered by a terminal order
        need = orderIn | intr | halt;
    end

endmodule

// ### verification/ioc_command_control_chk.sv
// port assertions for the channel command control block
`timescale 1ns/100ps
`include "ioc_defines.svh"
module ioc_command_control_chk (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // watched ports
    input wire logic orderOutReq,
    input wire logic orderInReq,
    input wire logic dataByteReq,
    input wire logic busy,
    input wire logic orderValid,
    input wire logic termValid,
    input wire logic dataMemEn,
    input wire logic instrValid,
    input wire logic memReq,
    input wire logic memWe,
    input wire logic [15:0] memAddr,
    input wire logic memAck
);
    // ----
    // properties
    // ----
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    AST_FETCH: assert property (orderOutReq && !busy |=> busy && memReq)
        else $error("order out did not start a fetch");
    AST_HOLD: assert property (memReq && !memAck |=> memReq && $stable(memAddr))
        else $error("fetch request dropped or moved");
    AST_TERM: assert property (orderInReq && !busy && !orderOutReq |=> termValid)
        else $error("order in without terminal order");
    AST_FWD: assert property (orderValid |-> $past(memAck))
        else $error("order forwarded away from a memory read");
    AST_TSRC: assert property (termValid |-> $past(orderInReq || dataByteReq || memAck))
        else $error("terminal order without a cause");
    AST_DMEM: assert property (dataMemEn |-> $past(dataByteReq))
        else $error("data access without a byte request");
    AST_INSTR: assert property (instrValid |-> busy ##1 !instrValid)
        else $error("instruction pulse malformed");
    AST_CELL: assert property (memReq && memWe |-> memAddr == `IOC_CELL20 || memAddr == `IOC_CELL21)
        else $error("write outside the return cells");
endmodule
bind ioc_command_control ioc_command_control_chk chk (.*);

// ### verification/ioc_far_model.sv
// device controller and memory stand-in beside the command control block
`timescale 1ns/100ps
module ioc_far_model import ioc_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // from the block, and slow from the bench
    input wire logic busy,
    input wire logic termValid,
    input wire logic [7:0] termByte,
    input wire logic instrValid,
    input wire logic [1:0] instrCode,
    input wire logic memReq,
    input wire logic memWe,
    input wire logic [15:0] memAddr,
    input wire logic [31:0] memWdata,
    input wire logic slow,
    // to the block
    output logic orderOutReq,
    output logic instrDone,
    output logic [14:0] instrStatus,
    output logic [7:0] instrDevStatus,
    output logic memAck,
    output logic [31:0] memRdata,
    output logic memParErr
);
    // ----
    // behaviour
    // ----
    logic [31:0] mem [0:63];
    logic pend;
    logic [1:0] dly;
    logic [1:0] wt;
    assign instrStatus = 15'h1357;
    assign instrDevStatus = {8{slow}} ^ 8'hc3;
    assign memParErr = 1'b0;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pend <= 1'b0;
            orderOutReq <= 1'b0;
            dly <= 2'h0;
            instrDone <= 1'b0;
            memAck <= 1'b0;
            memRdata <= 32'h0;
            wt <= 2'h0;
        end else begin
            // order out after an accepted start, or after chaining is shown
            pend <= (pend && !orderOutReq) || (instrValid && instrCode == IN_START)
                || (termValid && termByte[2]);
            // requests made while the block is busy would be lost
            orderOutReq <= pend && !busy && !orderOutReq;
            dly <= {dly[0], instrValid};
            instrDone <= dly[1];
            memAck <= 1'b0;
            // an idle bus flips its data each cycle instead of holding the last word
            memRdata <= ~memRdata;
            if (memReq && !memAck) begin
                if (wt != 2'h0) begin
                    wt <= wt - 2'h1;
                end else begin
                    memAck <= 1'b1;
                    memRdata <= mem[memAddr[5:0]];
                    wt <= {slow, slow};
                    if (memWe) begin
                        mem[memAddr[5:0]] <= memWdata;
                    end
                end
            end
        end
    end
endmodule

// ### verification/test_io_channel_command_control.sv
// self-checking bench for the channel command control block
`timescale 1ns/100ps
module test_io_channel_command_control import ioc_pkg::*;;
    logic clk, rst_b, regWr, regRd, orderOutReq, orderInReq, dataByteReq, busy, slow, dvD;
    logic orderValid, termValid, dataMemEn, instrValid, instrDone, memReq, memWe, memAck;
    logic memParErr;
    logic [3:0] regAddr;
    logic [31:0] regWdata, regRdata, memWdata, memRdata, rv;
    logic [1:0] reqChan, ansChan, instrCode, ret, c;
    logic [7:0] orderInByte, orderByte, termByte, instrDev, instrDevStatus, fl, rf, ob, ib;
    logic [18:0] dataAddr, ba;
    logic [2:0] instrIop;
    logic [14:0] instrStatus;
    logic [15:0] memAddr;
    logic [10:0] ea;
    logic [19:0] expT[$], gotT[$], expO[$], gotO[$], expR[$], gotR[$], expA[$], gotA[$];
    logic [7:0] tab [5];
    int err_total, comparisons, seed, i;
    ioc_command_control DUT (.*);
    ioc_far_model far (.*);
    always #4 clk = ~clk;
    always @(posedge clk) begin
        if (termValid) gotT.push_back({10'h0, ansChan, termByte});
        if (orderValid) gotO.push_back({12'h0, orderByte});
        if (memReq && memAck && !memWe) gotR.push_back({14'h0, memAddr[5:0]});
        if (dvD) gotA.push_back({dataMemEn, dataAddr});
        dvD <= dataByteReq;
    end
    // ----
    // tasks
    // ----
    task chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic cq(ref logic [19:0] e[$], ref logic [19:0] g[$]);
        chk(g.size(), e.size());
        foreach (e[k])
            if (k < g.size()) chk(g[k], e[k]);
        e.delete();
        g.delete();
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask
    // n back-to-back cycles of one request kind
    task req(input logic oi, input int n, input logic [7:0] b);
        @(posedge clk);
        reqChan <= c;
        orderInByte <= b;
        if (oi) orderInReq <= 1'b1;
        else dataByteReq <= 1'b1;
        repeat (n) @(posedge clk);
        orderInReq <= 1'b0;
        dataByteReq <= 1'b0;
    endtask
    task idle;
        int n;
        n = 0;
        for (int k = 0; k < 400 && n < 4; k++) begin
            @(posedge clk);
            n = (busy || far.pend || orderOutReq) ? 0 : n + 1;
        end
    endtask
    task end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #400000;
        err_total++;
        end_sim;
    end
    // ----
    // sequence
    // ----
    initial begin
        {clk, rst_b, regWr, regRd, orderInReq, dataByteReq, slow, dvD} = '0;
        {regAddr, regWdata, reqChan, orderInByte} = '0;
        {err_total, comparisons, seed} = '0;
        seed = 1;
        tab = '{8'hfd, 8'hfe, 8'hff, 8'hfc, 8'hf4};
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        rd(4'hf, rv);
        chk(rv, 32'h0);
        for (i = 0; i < 24; i++) begin
            fl = 8'($random(seed));
            rf = {<<{fl}};
            ob = tab[{$random(seed)} % 5];
            ret = 2'({$random(seed)} % 3);
            c = i[1:0];
            reqChan <= c;
            ea = {11'($random(seed)) & 11'h7fc} | {9'h0, c};
            slow <= 1'($random(seed));
            ba = 19'h00100 + 19'(i);
            for (int k = 8; k < 14; k += 2) begin
                far.mem[k] = {ob, 5'h0, ba};
                far.mem[k + 1] = {rf, 8'h0, 16'hfffe};
            end
            far.mem[32] = 32'h55555555;
            far.mem[33] = 32'h55555555;
            wr(4'h2, {30'h0, c});
            wr(4'h1, 32'h8);
            wr(4'h0, {17'h0, ret, 2'h0, ea});
            expO.push_back({12'h0, ob});
            expR.push_back(20'h8);
            expR.push_back(20'h9);
            idle();
            chk(far.mem[32][15:0], ret != 2'h0 ? {5'h0, ea} : 16'h5555);
            chk(far.mem[33][31:17], ret == 2'h2 ? 15'h1357 : 15'h2aaa);
            rd(4'h3, rv);
            chk(rv[7:0], fl);
            ib = 8'($random(seed)) & 8'h1b;
            req(1'b1, 1, ib);
            expT.push_back({c, 4'h0, fl[4] & (ib[0] | ib[1] & !fl[6]), fl[2] & ib[3], 1'b0,
                fl[3] & ib[3] | fl[5] & ib[4]});
            if (fl[2] & ib[3]) begin
                expO.push_back({12'h0, ob});
                expR.push_back(20'ha);
                expR.push_back(20'hb);
            end
            idle();
            req(1'b0, 2, 8'h0);
            expA.push_back({!fl[7], ba});
            expA.push_back({!fl[7], ob == 8'hfc ? ba - 19'h1 : ba + 19'h1});
            if (fl[1]) expT.push_back({c, 8'h1});
            if (fl[0]) begin
                expR.push_back((fl[2] & ib[3]) ? 20'hc : 20'ha);
                expR.push_back((fl[2] & ib[3]) ? 20'hd : 20'hb);
            end
            idle();
            cq(expT, gotT);
            cq(expO, gotO);
            cq(expR, gotR);
            cq(expA, gotA);
            $display("test %0d done", i);
        end
        far.mem[8] = {8'h88, 8'h0, 16'h0030};
        far.mem[48] = 32'h80000000;
        wr(4'h2, {30'h0, c});
        wr(4'h1, 32'h8);
        wr(4'h0, {30'h0, c});
        expO.push_back(20'h80);
        idle();
        cq(expO, gotO);
        rd(4'h3, rv);
        chk(rv[7:0], fl);
        gotR.delete();
        for (int op = 1; op < 4; op++) begin
            far.mem[33] = 32'h55555555;
            wr(4'h0, {17'h0, 2'h2, 2'(op), 11'h5});
            idle();
            chk(far.mem[33][31:17],
                op == 3 ? {8'hc3 ^ {8{slow}}, 7'h57} : 15'h1357);
        end
        $display("test branch and instructions done");
        end_sim;
    end
endmodule
